/* ctp_pkg.sv */
package ctp_pkg;
	localparam logic [15:0] ADR_LOW_COUNT_A    = 16'h0106;
	localparam logic [15:0] ADR_HIGH_HOLD_A    = 16'h0108;
	localparam logic [15:0] ADR_HIGH_COUNT_A   = 16'h010A;
	localparam logic [15:0] ADR_LOW_PERIOD_A   = 16'h010C;
	localparam logic [15:0] ADR_HIGH_PERIOD_A  = 16'h010E;
	localparam logic [15:0] ADR_LOW_CONTROL_A  = 16'h0110;
	localparam logic [15:0] ADR_HIGH_CONTROL_A = 16'h0112;
	localparam logic [15:0] ADR_LOW_COUNT_B    = 16'h0114;
	localparam logic [15:0] ADR_HIGH_HOLD_B    = 16'h0116;
	localparam logic [15:0] ADR_HIGH_COUNT_B   = 16'h0118;
	localparam logic [15:0] ADR_LOW_PERIOD_B   = 16'h011A;
	localparam logic [15:0] ADR_HIGH_PERIOD_B  = 16'h011C;
	localparam logic [15:0] ADR_LOW_CONTROL_B  = 16'h011E;
	localparam logic [15:0] ADR_HIGH_CONTROL_B = 16'h0120;
	localparam logic [15:0] ADR_IRQ_FLAG       = 16'h0122;
	localparam logic [15:0] ADR_IRQ_ENABLE     = 16'h0124;
	localparam logic [15:0] ADR_BLOCK_SPAN     = 16'h0020;

	localparam int BIT_TIMER_ON      = 15;
	localparam int BIT_STOP_IN_IDLE  = 13;
	localparam int BIT_GATE_ENABLE   = 6;
	localparam int BIT_PRESCALE_HI   = 5;
	localparam int BIT_PRESCALE_LO   = 4;
	localparam int BIT_PAIR_COMBINE  = 3;
	localparam int BIT_CLOCK_SOURCE  = 1;
	localparam logic [15:0] CONTROL_LOW_MASK  = 16'hA07A;
	localparam logic [15:0] CONTROL_HIGH_MASK = 16'hA072;

	// Flag and enable register layout: per pair two bits
	localparam int BIT_LOW_IRQ_A  = 6;
	localparam int BIT_HIGH_IRQ_A = 7;
	localparam int BIT_LOW_IRQ_B  = 11;
	localparam int BIT_HIGH_IRQ_B = 12;

	localparam logic [15:0] RST_PERIOD   = 16'hFFFF;
	localparam logic [15:0] RST_CONTROL  = 16'h0000;
	localparam logic [15:0] RST_COUNT    = 16'h0000;
	localparam logic [7:0]  PRESCALE_1   = 8'h00;
	localparam logic [7:0]  PRESCALE_8   = 8'h07;
	localparam logic [7:0]  PRESCALE_64  = 8'h3F;
	localparam logic [7:0]  PRESCALE_256 = 8'hFF;

	typedef enum logic [2:0] {
		CTP_OFF   = 3'b001,
		CTP_SPLIT = 3'b010,
		CTP_PAIR  = 3'b100
	} ctp_mode_e;
endpackage : ctp_pkg

/* ctp_bus_if.sv */
`timescale 1ns/1ps
interface ctp_bus_if;
	logic [15:0] addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	modport master (output addr, output wdata, output wr, output rd, input rdata);
	modport slave  (input addr, input wdata, input wr, input rd, output rdata);
endinterface : ctp_bus_if

/* ctp_pair.sv */
`timescale 1ns/1ps
module ctp_pair #(
	parameter logic [15:0] BASE = 16'h0106
) (
	input  wire logic        i_clock,
	input  wire logic        i_reset_n,
	ctp_bus_if.slave         bus,
	input  wire logic        i_idle,
	input  wire logic        i_sleep,
	input  wire logic        i_low_pin,
	input  wire logic        i_high_pin,
	output logic             o_low_event,
	output logic             o_high_event,
	output logic             o_high_match
);
	import ctp_pkg::*;

	logic [15:0] low_count_ff, high_count_ff, high_hold_ff;
	logic [15:0] low_period_ff, high_period_ff, low_control_ff, high_control_ff;
	logic [7:0]  low_pre_ff, high_pre_ff;
	logic [2:0]  low_pin_ff, high_pin_ff;
	logic        low_tick_ff;
	logic [15:0] rd_mux;
	ctp_mode_e   mode;

	function automatic logic [7:0] pre_limit(input logic [1:0] sel);
		unique case (sel)
			2'b00: pre_limit = PRESCALE_1;
			2'b01: pre_limit = PRESCALE_8;
			2'b10: pre_limit = PRESCALE_64;
			default: pre_limit = PRESCALE_256;
		endcase
	endfunction : pre_limit

	function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
		hit = (a == BASE + off);
	endfunction : hit

	logic wr_lc, wr_hh, wr_hc, wr_lp, wr_hp, wr_lctl, wr_hctl;
	assign wr_lc   = bus.wr && hit(bus.addr, 16'h0000);
	assign wr_hh   = bus.wr && hit(bus.addr, 16'h0002);
	assign wr_hc   = bus.wr && hit(bus.addr, 16'h0004);
	assign wr_lp   = bus.wr && hit(bus.addr, 16'h0006);
	assign wr_hp   = bus.wr && hit(bus.addr, 16'h0008);
	assign wr_lctl = bus.wr && hit(bus.addr, 16'h000A);
	assign wr_hctl = bus.wr && hit(bus.addr, 16'h000C);

	logic combine, low_on, high_on, low_run, high_run;
	assign combine  = low_control_ff[BIT_PAIR_COMBINE];
	assign low_on   = low_control_ff[BIT_TIMER_ON];
	assign high_on  = high_control_ff[BIT_TIMER_ON] && !combine;
	// Sleep halts all clocks; idle only with stop-in-idle
	assign low_run  = low_on && !i_sleep
		&& !(i_idle && low_control_ff[BIT_STOP_IN_IDLE]);
	assign high_run = high_on && !i_sleep
		&& !(i_idle && high_control_ff[BIT_STOP_IN_IDLE]);

	always_comb begin
		if (!low_on && !high_on)
			mode = CTP_OFF;
		else if (combine)
			mode = CTP_PAIR;
		else
			mode = CTP_SPLIT;
	end

	// Pin edge detection; pins are asynchronous and pass two synchroniser flops
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			low_pin_ff  <= 3'h0;
			high_pin_ff <= 3'h0;
		end else begin
			low_pin_ff  <= {low_pin_ff[1:0], i_low_pin};
			high_pin_ff <= {high_pin_ff[1:0], i_high_pin};
		end
	end

	logic low_gated, high_gated, low_gate_fall, high_gate_fall;
	logic low_src, high_src;
	assign low_gated  = low_control_ff[BIT_GATE_ENABLE] && !low_control_ff[BIT_CLOCK_SOURCE];
	// High timer gate ignored in pair mode
	assign high_gated = high_control_ff[BIT_GATE_ENABLE] && !high_control_ff[BIT_CLOCK_SOURCE]
		&& !combine;
	assign low_gate_fall  = low_on && low_gated && low_pin_ff[2] && !low_pin_ff[1];
	assign high_gate_fall = high_on && high_gated && high_pin_ff[2] && !high_pin_ff[1];

	// Counter mode counts synchronised rising edges; gated counts cycles while high
	always_comb begin
		if (low_control_ff[BIT_CLOCK_SOURCE])
			low_src = low_pin_ff[1] && !low_pin_ff[2];
		else if (low_gated)
			low_src = low_pin_ff[1];
		else
			low_src = 1'b1;
	end
	always_comb begin
		if (high_control_ff[BIT_CLOCK_SOURCE])
			high_src = high_pin_ff[1] && !high_pin_ff[2];
		else if (high_gated)
			high_src = high_pin_ff[1];
		else
			high_src = 1'b1;
	end

	logic low_pre_done, high_tick;
	assign low_pre_done = low_run && low_src
		&& low_pre_ff == pre_limit(low_control_ff[BIT_PRESCALE_HI:BIT_PRESCALE_LO]);
	assign high_tick = high_run && high_src
		&& high_pre_ff == pre_limit(high_control_ff[BIT_PRESCALE_HI:BIT_PRESCALE_LO]);

	// Prescalers: cleared by count or control writes; the low one only while its timer is on
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			low_pre_ff <= 8'h00;
		end else if ((wr_lc || wr_lctl) && low_on) begin
			low_pre_ff <= 8'h00;
		end else if (low_run && low_src) begin
			low_pre_ff <= low_pre_done ? 8'h00 : low_pre_ff + 8'h01;
		end
	end
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			high_pre_ff <= 8'h00;
		end else if (wr_hc || wr_hctl) begin
			high_pre_ff <= 8'h00;
		end else if (high_run && high_src) begin
			high_pre_ff <= high_tick ? 8'h00 : high_pre_ff + 8'h01;
		end
	end

	// Low prescaler output retimed: costs one cycle of latency
	always_ff @(posedge i_clock) begin
		if (!i_reset_n)
			low_tick_ff <= 1'b0;
		else
			low_tick_ff <= low_pre_done && !(wr_lc || wr_lctl);
	end

	logic low_match, high_match16, pair_match;
	assign low_match    = low_count_ff == low_period_ff;
	assign high_match16 = high_count_ff == high_period_ff;
	assign pair_match   = low_match && high_match16;

	logic [31:0] pair_next;
	assign pair_next = {high_count_ff, low_count_ff} + 32'h0000_0001;

	// Count registers: count writes take priority over ticks
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			low_count_ff  <= RST_COUNT;
			high_count_ff <= RST_COUNT;
		end else begin
			if (wr_lc) begin
				low_count_ff <= bus.wdata;
				if (combine)
					high_count_ff <= high_hold_ff;
			end else if (mode == CTP_PAIR && low_tick_ff) begin
				if (pair_match) begin
					low_count_ff  <= RST_COUNT;
					high_count_ff <= RST_COUNT;
				end else begin
					low_count_ff  <= pair_next[15:0];
					high_count_ff <= pair_next[31:16];
				end
			end else if (mode == CTP_SPLIT && low_tick_ff) begin
				low_count_ff <= low_match ? RST_COUNT : low_count_ff + 16'h0001;
			end
			if (wr_hc)
				high_count_ff <= bus.wdata;
			else if (!combine && high_tick)
				high_count_ff <= high_match16 ? RST_COUNT : high_count_ff + 16'h0001;
		end
	end

	// Holding register, loaded by software or by a low-half read in pair mode
	always_ff @(posedge i_clock) begin
		if (!i_reset_n)
			high_hold_ff <= RST_COUNT;
		else if (wr_hh)
			high_hold_ff <= bus.wdata;
		else if (bus.rd && hit(bus.addr, 16'h0000) && combine)
			high_hold_ff <= high_count_ff;
	end

	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			low_period_ff   <= RST_PERIOD;
			high_period_ff  <= RST_PERIOD;
			low_control_ff  <= RST_CONTROL;
			high_control_ff <= RST_CONTROL;
		end else begin
			if (wr_lp)
				low_period_ff <= bus.wdata;
			if (wr_hp)
				high_period_ff <= bus.wdata;
			if (wr_lctl)
				low_control_ff <= bus.wdata & CONTROL_LOW_MASK;
			if (wr_hctl)
				high_control_ff <= bus.wdata & CONTROL_HIGH_MASK;
		end
	end

	// Event pulses toward the interrupt flags
	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			o_low_event  <= 1'b0;
			o_high_event <= 1'b0;
			o_high_match <= 1'b0;
		end else begin
			o_low_event  <= (mode == CTP_SPLIT && low_tick_ff && low_match && !wr_lc)
				|| (!combine && low_gate_fall);
			o_high_event <= (mode == CTP_PAIR && low_tick_ff && pair_match && !wr_lc)
				|| (combine && low_gate_fall)
				|| (!combine && high_tick && high_match16 && !wr_hc)
				|| (!combine && high_gate_fall);
			o_high_match <= (mode == CTP_PAIR && low_tick_ff && pair_match && !wr_lc)
				|| (!combine && high_tick && high_match16 && !wr_hc);
		end
	end

	// Read mux left open; the top registers the merged word once
	always_comb begin
		rd_mux = 16'h0000;
		if (bus.rd) begin
			unique case (bus.addr - BASE)
				16'h0000: rd_mux = low_count_ff;
				16'h0002: rd_mux = high_hold_ff;
				16'h0004: rd_mux = high_count_ff;
				16'h0006: rd_mux = low_period_ff;
				16'h0008: rd_mux = high_period_ff;
				16'h000A: rd_mux = low_control_ff;
				16'h000C: rd_mux = high_control_ff;
				default:  rd_mux = 16'h0000;
			endcase
		end
	end
	assign bus.rdata = rd_mux;
endmodule : ctp_pair

/* ctp_top.sv */
`timescale 1ns/1ps
module ctp_top (
	input  wire logic        i_clock,
	input  wire logic        i_reset_n,
	input  wire logic [15:0] i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [15:0] o_rdata,
	input  wire logic        i_idle,
	input  wire logic        i_sleep,
	input  wire logic        i_low_pin_a,
	input  wire logic        i_high_pin_a,
	input  wire logic        i_low_pin_b,
	input  wire logic        i_high_pin_b,
	output logic             o_adc_trigger,
	output logic      [15:0] o_irq_flags,
	output logic             o_irq_pending
);
	import ctp_pkg::*;

	ctp_bus_if bus_a ();
	ctp_bus_if bus_b ();
	logic ev_low_a, ev_high_a, match_a, ev_low_b, ev_high_b;
	logic [15:0] flag_ff, enable_ff, rdata_ff;
	logic        trig_ff, pend_ff;
	logic [15:0] sets;

	assign bus_a.addr  = i_addr;
	assign bus_a.wdata = i_wdata;
	assign bus_a.wr    = i_wr;
	assign bus_a.rd    = i_rd;
	assign bus_b.addr  = i_addr;
	assign bus_b.wdata = i_wdata;
	assign bus_b.wr    = i_wr;
	assign bus_b.rd    = i_rd;

	ctp_pair #(.BASE(ADR_LOW_COUNT_A)) u_pair_a (
		.i_clock      (i_clock),
		.i_reset_n    (i_reset_n),
		.bus          (bus_a.slave),
		.i_idle       (i_idle),
		.i_sleep      (i_sleep),
		.i_low_pin    (i_low_pin_a),
		.i_high_pin   (i_high_pin_a),
		.o_low_event  (ev_low_a),
		.o_high_event (ev_high_a),
		.o_high_match (match_a)
	);

	ctp_pair #(.BASE(ADR_LOW_COUNT_B)) u_pair_b (
		.i_clock      (i_clock),
		.i_reset_n    (i_reset_n),
		.bus          (bus_b.slave),
		.i_idle       (i_idle),
		.i_sleep      (i_sleep),
		.i_low_pin    (i_low_pin_b),
		.i_high_pin   (i_high_pin_b),
		.o_low_event  (ev_low_b),
		.o_high_event (ev_high_b),
		.o_high_match ()
	);

	// Only the first pair drives the converter trigger
	always_ff @(posedge i_clock) begin
		if (!i_reset_n)
			trig_ff <= 1'b0;
		else
			trig_ff <= match_a;
	end

	always_comb begin
		sets = 16'h0000;
		sets[BIT_LOW_IRQ_A]  = ev_low_a;
		sets[BIT_HIGH_IRQ_A] = ev_high_a;
		sets[BIT_LOW_IRQ_B]  = ev_low_b;
		sets[BIT_HIGH_IRQ_B] = ev_high_b;
	end

	// Flags: a set in the same cycle as a software clear wins
	always_ff @(posedge i_clock) begin
		if (!i_reset_n)
			flag_ff <= 16'h0000;
		else if (i_wr && i_addr == ADR_IRQ_FLAG)
			flag_ff <= i_wdata | sets;
		else
			flag_ff <= flag_ff | sets;
	end

	always_ff @(posedge i_clock) begin
		if (!i_reset_n)
			enable_ff <= 16'h0000;
		else if (i_wr && i_addr == ADR_IRQ_ENABLE)
			enable_ff <= i_wdata;
	end

	always_ff @(posedge i_clock) begin
		if (!i_reset_n)
			pend_ff <= 1'b0;
		else
			pend_ff <= |(flag_ff & enable_ff);
	end

	// Pairs return zero when not addressed, so an OR merges them
	always_ff @(posedge i_clock) begin
		if (!i_reset_n)
			rdata_ff <= 16'h0000;
		else if (i_rd && i_addr == ADR_IRQ_FLAG)
			rdata_ff <= flag_ff;
		else if (i_rd && i_addr == ADR_IRQ_ENABLE)
			rdata_ff <= enable_ff;
		else
			rdata_ff <= bus_a.rdata | bus_b.rdata;
	end

	assign o_rdata       = rdata_ff;

	assign o_adc_trigger = trig_ff;
	assign o_irq_flags   = flag_ff;
	assign o_irq_pending = pend_ff;
endmodule : ctp_top

/* ctp_pin_model.sv */
`timescale 1ns/1ps
module ctp_pin_model (
	input  wire logic       i_clock,
	input  wire logic       i_start,
	input  wire logic [7:0] i_count,
	input  wire logic [7:0] i_width,
	output logic            o_pin
);
	logic [7:0] left_ff = 8'h00;
	logic [7:0] ph_ff   = 8'h00;
	logic       wrap;
	assign wrap = (ph_ff == 8'(2 * i_width - 1));
	// Burst of equal high and low phases; rests low like a pulled-down pin
	always_ff @(posedge i_clock) begin
		if (i_start) begin
			left_ff <= i_count;
			ph_ff   <= 8'h00;
		end else if (left_ff != 8'h00) begin
			ph_ff <= wrap ? 8'h00 : ph_ff + 8'h01;
			if (wrap) begin
				left_ff <= left_ff - 8'h01;
			end
		end
	end
	assign o_pin = (left_ff != 8'h00) && (ph_ff < i_width);
endmodule : ctp_pin_model

/* ctp_top_chk.sv */
`timescale 1ns/1ps
module ctp_top_chk
	import ctp_pkg::*;
(
	input wire logic        i_clock,
	input wire logic        i_reset_n,
	input wire logic [15:0] i_addr,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic        i_sleep,
	input wire logic [15:0] o_rdata,
	input wire logic        o_adc_trigger,
	input wire logic [15:0] o_irq_flags,
	input wire logic        o_irq_pending
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_reset_n);
	// Sleep must outlast tick retiming and the flag pipeline
	sequence sleep_held;
		i_sleep [*5];
	endsequence
	sequence ctl_read(a);
		i_rd && i_addr == a;
	endsequence
	rd_quiet_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
		else $error("read data outside read cycle");
	low_ctl_a: assert property (
		ctl_read(ADR_LOW_CONTROL_A) |=> (o_rdata & ~CONTROL_LOW_MASK) == 16'h0000)
		else $error("low control reserved bits set");
	high_ctl_a: assert property (
		ctl_read(ADR_HIGH_CONTROL_B) |=> (o_rdata & ~CONTROL_HIGH_MASK) == 16'h0000)
		else $error("high control reserved bits set");
	flag_sticky_a: assert property (
		(|($past(o_irq_flags) & ~o_irq_flags)) |-> $past(i_wr) && $past(i_addr) == ADR_IRQ_FLAG)
		else $error("flag dropped without software write");
	adc_flag_a: assert property (o_adc_trigger |-> o_irq_flags[BIT_HIGH_IRQ_A])
		else $error("trigger without high flag");
	pend_cause_a: assert property (o_irq_pending |-> $past(o_irq_flags) != 16'h0000)
		else $error("pending without flag");
	pend_drop_a: assert property (o_irq_flags == 16'h0000 |=> !o_irq_pending)
		else $error("pending stuck");
	sleep_quiet_a: assert property (sleep_held |=> !o_adc_trigger)
		else $error("trigger during sleep");
	reset_clear_a: assert property (disable iff (1'b0)
		!i_reset_n |=> o_irq_flags == 16'h0000 && !o_adc_trigger && !o_irq_pending)
		else $error("outputs not cleared by reset");
endmodule : ctp_top_chk
bind ctp_top ctp_top_chk ctp_top_chk_i (
	.i_clock(i_clock), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
	.i_sleep(i_sleep), .o_rdata(o_rdata), .o_adc_trigger(o_adc_trigger),
	.o_irq_flags(o_irq_flags), .o_irq_pending(o_irq_pending));

/* ctp_top_tb_top.sv */
`timescale 1ns/1ps
module ctp_top_tb_top;
	import ctp_pkg::*;
	logic        i_clock   = 1'b0;
	logic        i_reset_n = 1'b0;
	logic [15:0] i_addr    = 16'h0000;
	logic [15:0] i_wdata   = 16'h0000;
	logic        i_wr      = 1'b0;
	logic        i_rd      = 1'b0;
	logic        i_idle    = 1'b0;
	logic        i_sleep   = 1'b0;
	logic        p_start   = 1'b0;
	logic [7:0]  p_count   = 8'h00;
	logic [7:0]  p_width   = 8'h01;
	logic        pin;
	logic [15:0] o_rdata;
	logic [15:0] o_irq_flags;
	logic        o_adc_trigger;
	logic        o_irq_pending;
	logic [15:0] got;
	logic [15:0] c0;
	logic [15:0] pdiv [4] = '{16'h0100, 16'h0020, 16'h0004, 16'h0001};
	int          n_fail          = 0;
	int          samples_checked = 0;
	int          cycles          = 0;
	always #12.5 i_clock = ~i_clock;
	ctp_pin_model ctp_pin_model_i (.i_clock(i_clock), .i_start(p_start), .i_count(p_count),
		.i_width(p_width), .o_pin(pin));
	// One pin model feeds both low pins; pair A is stopped while pair B uses it
	ctp_top ctp_top_i (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_idle(i_idle),
		.i_sleep(i_sleep), .i_low_pin_a(pin), .i_high_pin_a(1'b0), .i_low_pin_b(pin),
		.i_high_pin_b(1'b0), .o_adc_trigger(o_adc_trigger), .o_irq_flags(o_irq_flags),
		.o_irq_pending(o_irq_pending));
	task automatic summarize();
		if (n_fail == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : summarize
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		samples_checked++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge i_clock);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a);
		@(posedge i_clock);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_rd <= 1'b0;
		@(negedge i_clock);
		got = o_rdata;
	endtask : rd
	task automatic rdc(input string n, input logic [15:0] a, input logic [15:0] e);
		rd(a);
		chk(n, e, got);
	endtask : rdc
	// Reads 256 cycles apart, so any prescale phase gives an exact difference
	task automatic rate(input logic [15:0] ctl, input logic [15:0] e);
		wr(ADR_LOW_CONTROL_B, ctl);
		rd(ADR_LOW_COUNT_B);
		c0 = got;
		repeat (254) @(posedge i_clock);
		rd(ADR_LOW_COUNT_B);
		chk("count_rate", e, got - c0);
	endtask : rate
	task automatic trig(output int t);
		t = 0;
		do begin
			@(negedge i_clock);
			t++;
		end while (o_adc_trigger !== 1'b1 && t < 500);
	endtask : trig
	task automatic gap(input int e);
		int t;
		trig(t);
		trig(t);
		chk("trigger_gap", 16'(e), 16'(t));
	endtask : gap
	task automatic pulse(input logic [7:0] n, input logic [7:0] w);
		@(posedge i_clock);
		p_count <= n;
		p_width <= w;
		p_start <= 1'b1;
		@(posedge i_clock);
		p_start <= 1'b0;
		repeat (2 * n * w + 8) @(posedge i_clock);
	endtask : pulse
	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		if (cycles == 10000) begin
			n_fail++;
			summarize();
		end
	end
	initial begin
		repeat (16) @(posedge i_clock);
		i_reset_n <= 1'b1;
		rdc("low_period_a", ADR_LOW_PERIOD_A, RST_PERIOD);
		rdc("high_period_b", ADR_HIGH_PERIOD_B, RST_PERIOD);
		rdc("low_control_a", ADR_LOW_CONTROL_A, RST_CONTROL);
		rdc("high_count_b", ADR_HIGH_COUNT_B, RST_COUNT);
		rdc("unmapped", 16'h0100, 16'h0000);
		wr(ADR_HIGH_CONTROL_B, 16'h7FFF);
		rdc("high_control_b", ADR_HIGH_CONTROL_B, 16'h7FFF & CONTROL_HIGH_MASK);
		wr(ADR_LOW_COUNT_A, 16'h1234);
		wr(ADR_LOW_CONTROL_A, 16'h0030);
		rdc("count_kept", ADR_LOW_COUNT_A, 16'h1234);
		wr(ADR_HIGH_PERIOD_A, 16'h0003);
		wr(ADR_HIGH_CONTROL_A, 16'h8000);
		gap(4);
		chk("split_flags", 16'h0080, o_irq_flags & 16'h00C0);
		wr(ADR_IRQ_ENABLE, 16'h0080);
		repeat (2) @(negedge i_clock);
		chk("pending", 16'h0001, {15'h0000, o_irq_pending});
		wr(ADR_HIGH_CONTROL_A, 16'h0000);
		repeat (4) @(posedge i_clock);
		wr(ADR_IRQ_FLAG, 16'h0000);
		rdc("flags_clear", ADR_IRQ_FLAG, 16'h0000);
		wr(ADR_LOW_PERIOD_A, 16'h0005);
		wr(ADR_HIGH_PERIOD_A, 16'h0000);
		wr(ADR_LOW_CONTROL_A, 16'h0008);
		wr(ADR_HIGH_HOLD_A, 16'h0000);
		wr(ADR_LOW_COUNT_A, 16'h0000);
		wr(ADR_LOW_CONTROL_A, 16'h8008);
		gap(6);
		chk("pair_flags", 16'h0080, o_irq_flags & 16'h00C0);
		wr(ADR_LOW_CONTROL_A, 16'h0008);
		wr(ADR_HIGH_HOLD_A, 16'h00AB);
		wr(ADR_LOW_COUNT_A, 16'h1111);
		wr(ADR_HIGH_CONTROL_A, 16'h8030);
		wr(ADR_HIGH_HOLD_A, 16'h0000);
		rdc("high_from_hold", ADR_HIGH_COUNT_A, 16'h00AB);
		rdc("low_half", ADR_LOW_COUNT_A, 16'h1111);
		rdc("hold_latched", ADR_HIGH_HOLD_A, 16'h00AB);
		wr(ADR_LOW_CONTROL_A, 16'h800A);
		pulse(8'h0A, 8'h02);
		wr(ADR_LOW_CONTROL_A, 16'h0008);
		rdc("pair_ext_low", ADR_LOW_COUNT_A, 16'h111B);
		rdc("pair_ext_high", ADR_HIGH_HOLD_A, 16'h00AB);
		wr(ADR_LOW_COUNT_B, 16'h0000);
		wr(ADR_LOW_CONTROL_B, 16'h8040);
		pulse(8'h01, 8'h14);
		rdc("gated_count", ADR_LOW_COUNT_B, 16'h0014);
		repeat (20) @(posedge i_clock);
		rdc("gated_hold", ADR_LOW_COUNT_B, 16'h0014);
		chk("gate_flag", 16'h0800, o_irq_flags & 16'h1800);
		wr(ADR_LOW_COUNT_B, 16'h0000);
		wr(ADR_LOW_CONTROL_B, 16'h8002);
		pulse(8'h0A, 8'h02);
		rdc("split_ext", ADR_LOW_COUNT_B, 16'h000A);
		for (int k = 0; k < 4; k++) begin
			rate(16'h8000 | 16'(k << 4), pdiv[k]);
		end
		@(posedge i_clock);
		i_idle <= 1'b1;
		rate(16'hA000, 16'h0000);
		rate(16'h8000, 16'h0100);
		@(posedge i_clock);
		i_idle  <= 1'b0;
		i_sleep <= 1'b1;
		rate(16'h8000, 16'h0000);
		@(posedge i_clock);
		i_sleep <= 1'b0;
		summarize();
	end
endmodule : ctp_top_tb_top
